// ### src/cfs_top.sv
// Compressor fault supervisor: fault latches, motor interlock, restart and display.
`timescale 1ns/1ps

module cfs_top #(
    parameter int TICK_CYCLES = cfs_pkg::CLK_HZ     // Clock cycles per second tick.
) (
    input  wire logic                    sys_clk_i,      // System clock, 200 MHz.
    input  wire logic                    reset_n_i,      // Synchronous reset, active low.
    input  wire logic                    ce_i,           // Clock enable; low freezes all.
    input  wire logic [7:0]              he_temp_i,      // Helium discharge temp, deg C.
    input  wire logic [7:0]              water_temp_i,   // Water supply temp, deg C.
    input  wire logic [7:0]              ret_press_i,    // Return pressure, psig.
    input  wire logic                    flow_err_i,     // Low water flow detected.
    input  wire logic                    motor_err_i,    // Motor protector open.
    input  wire logic                    phase_err_i,    // Phase sequence or fuse fault.
    input  wire logic                    cfg_sw_i,       // Local switch: 1 selects mode 2.
    input  wire logic                    cfg_cable_i,    // Mode wired by remote cable.
    input  wire logic                    btn_up_i,       // Display up button.
    input  wire logic                    btn_dn_i,       // Display down button.
    input  wire logic                    remote_clr_i,   // Connector clear signal.
    input  wire logic                    on_req_i,       // Operator run request.
    input  wire logic [cfs_pkg::NPT-1:0] sens_open_i,    // Sensor disconnected flags.
    input  wire logic                    psel,           // APB select.
    input  wire logic                    penable,        // APB enable.
    input  wire logic                    pwrite,         // APB write.
    input  wire logic [11:0]             paddr,          // APB byte address.
    input  wire logic [31:0]             pwdata,         // APB write data.
    output logic                         pready,         // APB ready, always high.
    output logic [31:0]                  prdata,         // APB read data.
    output logic                         pslverr,        // APB error on unmapped address.
    output logic                         comp_drive_o,   // Compressor motor drive.
    output logic                         coldhead_drive_o, // Cold-head valve drive.
    output logic [cfs_pkg::NPT-1:0]      diag_err_o,     // Connector error lines.
    output cfs_pkg::cfs_line_type        disp_line_o,    // Display line shown.
    output cfs_pkg::cfs_disp_type        disp_state_o    // Indication of that line.
);

    // Elaboration guard: the prescaler counter is only 28 bits wide.
    if (TICK_CYCLES < 2 || TICK_CYCLES > 2 ** 28) begin : g_tick_check
        $error("TICK_CYCLES out of range");
    end

    cfs_pkg::cfs_state_type st_r;
    cfs_pkg::cfs_state_type st_nxt;
    cfs_pkg::cfs_pin_type   pins;
    logic [cfs_pkg::NPT-1:0] cond;
    logic                    tick;
    logic                    up_ev;
    logic                    dn_ev;
    logic                    both_ev;
    logic                    rclr_ev;
    logic                    apb_acc;
    logic                    apb_map;
    logic                    soft_clr;
    logic                    clr_req;
    logic                    he_hold;
    logic [cfs_pkg::NPT-1:0] clr_mask;

    // ==========================================================
    // Pin capture and fault conditions
    // ==========================================================
    // The mains switch overload trip has no input here at all.
    assign pins = '{he_temp: he_temp_i, water_temp: water_temp_i, ret_press: ret_press_i,
                    flow_err: flow_err_i, motor_err: motor_err_i, phase_err: phase_err_i,
                    cfg_sw: cfg_sw_i, cfg_cable: cfg_cable_i, btn_up: btn_up_i,
                    btn_dn: btn_dn_i, remote_clr: remote_clr_i, on_req: on_req_i,
                    sens_open: sens_open_i};

    // A disconnected sensor reads garbage, so it raises no error of its own.
    always_comb begin
        cond = '0;
        cond[cfs_pkg::P_HE] = st_r.s2.he_temp > cfs_pkg::HE_LIMIT;
        cond[cfs_pkg::P_WT] = st_r.s2.water_temp > cfs_pkg::WT_LIMIT;
        cond[cfs_pkg::P_WF] = st_r.s2.flow_err;
        cond[cfs_pkg::P_MT] = st_r.s2.motor_err;
        cond[cfs_pkg::P_PH] = st_r.s2.phase_err;
        cond[cfs_pkg::P_RP] = st_r.s2.ret_press < cfs_pkg::RP_LIMIT;
        cond[cfs_pkg::P_CF] = st_r.s2.cfg_sw != st_r.s2.cfg_cable;
        cond = cond & ~st_r.s2.sens_open;
    end

    // ==========================================================
    // Events and APB decode
    // ==========================================================
    // Edges are taken from the second synchroniser stage only.
    assign tick    = st_r.pre == 28'(TICK_CYCLES - 1);
    assign up_ev   = st_r.s2.btn_up & ~st_r.up_q;
    assign dn_ev   = st_r.s2.btn_dn & ~st_r.dn_q;
    assign both_ev = (up_ev | dn_ev) & st_r.s2.btn_up & st_r.s2.btn_dn;
    assign rclr_ev = st_r.s2.remote_clr & ~st_r.rclr_q;
    assign apb_acc = psel & penable;
    assign apb_map = paddr == cfs_pkg::A_STATUS || paddr == cfs_pkg::A_CTRL;
    assign soft_clr = apb_acc & pwrite & paddr == cfs_pkg::A_CTRL & pwdata[cfs_pkg::CTRL_CLR];

    // Remote and software clears request a clear in both modes, the buttons only in mode 1.
    assign clr_req = rclr_ev | soft_clr | (both_ev & ~st_r.s2.cfg_sw);
    // In mode 2 a helium clear is ignored early in a retry interval to stop
    // the compressor from cycling on and off.
    assign he_hold = st_r.s2.cfg_sw & st_r.rs == cfs_pkg::RS_WAIT
                     & st_r.rsec < cfs_pkg::HOLD_SEC;
    always_comb begin
        clr_mask = clr_req ? '1 : '0;
        clr_mask[cfs_pkg::P_HE] = clr_req & ~he_hold;
    end

    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~apb_map;
    assign prdata  = st_r.prdata;
    assign comp_drive_o     = st_r.drive;
    assign coldhead_drive_o = st_r.drive;
    assign diag_err_o       = st_r.err;
    assign disp_line_o      = st_r.line;
    assign disp_state_o     = st_r.dstate;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.up_q = st_r.s2.btn_up;
        st_nxt.dn_q = st_r.s2.btn_dn;
        st_nxt.rclr_q = st_r.s2.remote_clr;
        st_nxt.pre = tick ? '0 : st_r.pre + 28'h1;

        // Present conditions keep their latch set: the set wins over a clear.
        st_nxt.err = (st_r.err & ~clr_mask) | cond;

        // Automatic restart after a helium over-temperature shutdown.
        case (st_r.rs)
            cfs_pkg::RS_IDLE: begin
                if (st_nxt.err[cfs_pkg::P_HE] && st_r.auto_en) begin
                    st_nxt.rs   = cfs_pkg::RS_WAIT;
                    st_nxt.rsec = '0;
                end
            end
            cfs_pkg::RS_WAIT: begin
                if (tick) begin
                    st_nxt.rsec = st_r.rsec + 11'h1;
                end
                if (tick && st_r.rsec == cfs_pkg::RETRY_SEC - 11'h1) begin
                    st_nxt.rsec  = '0;
                    st_nxt.tries = st_r.tries + 3'h1;
                    if (!cond[cfs_pkg::P_HE]) begin
                        st_nxt.err[cfs_pkg::P_HE] = 1'b0;
                        st_nxt.rs = cfs_pkg::RS_IDLE;
                    end
                    if (st_r.tries == cfs_pkg::MAX_TRIES - 3'h1 && cond[cfs_pkg::P_HE]) begin
                        st_nxt.rs = cfs_pkg::RS_LOCK;
                    end
                end
            end
            cfs_pkg::RS_LOCK: begin
                st_nxt.rs = cfs_pkg::RS_LOCK;
            end
            default: begin
                st_nxt.rs = cfs_pkg::RS_IDLE;
            end
        endcase
        // Once the attempts are spent only an external clear starts again.
        if (st_r.rs == cfs_pkg::RS_IDLE && st_r.tries == cfs_pkg::MAX_TRIES
                && st_nxt.err[cfs_pkg::P_HE]) begin
            st_nxt.rs = cfs_pkg::RS_LOCK;
        end
        if (clr_mask[cfs_pkg::P_HE]) begin
            st_nxt.tries = '0;
            if (!cond[cfs_pkg::P_HE]) begin
                st_nxt.rs = cfs_pkg::RS_IDLE;
            end
        end

        // Motor drives follow the run request unless a shutdown is latched.
        st_nxt.drive = st_r.s2.on_req & ~|(st_nxt.err & cfs_pkg::SHUT_MASK);

        // Display stepping with wrap; the cold-head line only while stopped.
        if (!both_ev && (up_ev || dn_ev)) begin
            st_nxt.idle_run = 1'b1;
            st_nxt.isec = '0;
            if (dn_ev) begin
                st_nxt.line = (st_r.line >= cfs_pkg::L_SW && st_r.drive)
                    || st_r.line == cfs_pkg::L_CH ? cfs_pkg::L_ET
                    : cfs_pkg::cfs_line_type'(st_r.line + 4'h1);
            end else begin
                st_nxt.line = st_r.line == cfs_pkg::L_ET
                    ? (st_r.drive ? cfs_pkg::L_SW : cfs_pkg::L_CH)
                    : cfs_pkg::cfs_line_type'(st_r.line - 4'h1);
            end
        end else if (st_r.idle_run && tick) begin
            st_nxt.isec = st_r.isec + 5'h1;
            if (st_r.isec == cfs_pkg::IDLE_CNT - 5'h1) begin
                st_nxt.idle_run = 1'b0;
                st_nxt.line = cfs_pkg::L_ET;
            end
        end
        if (st_r.drive && st_nxt.line == cfs_pkg::L_CH) begin
            st_nxt.line = cfs_pkg::L_ET;
        end
        // Newly failed points jump to the top; the highest index wins a tie,
        // and older errors stay latched so scrolling still finds them.
        for (int i = 0; i < cfs_pkg::NPT; i++) begin
            if (st_nxt.err[i] && !st_r.err[i]) begin
                st_nxt.line = cfs_pkg::pt_line(i);
            end
        end

        // Indication of the shown line: FAIL beats ERR beats OK.
        st_nxt.dstate = cfs_pkg::DS_INFO;
        for (int i = 0; i < cfs_pkg::NPT; i++) begin
            if (cfs_pkg::pt_line(i) == st_nxt.line) begin
                st_nxt.dstate = st_r.s2.sens_open[i] ? cfs_pkg::DS_FAIL
                    : st_nxt.err[i] ? cfs_pkg::DS_ERR
                    : cfs_pkg::DS_OK;
            end
        end

        // Register writes and the read word captured in the setup phase.
        if (apb_acc && pwrite && paddr == cfs_pkg::A_CTRL) begin
            st_nxt.auto_en = pwdata[cfs_pkg::CTRL_AUTO];
        end
        if (psel && !penable) begin
            st_nxt.prdata = '0;
            if (paddr == cfs_pkg::A_STATUS) begin
                st_nxt.prdata[cfs_pkg::ST_ERR +: cfs_pkg::NPT]  = st_r.err;
                st_nxt.prdata[cfs_pkg::ST_FAIL +: cfs_pkg::NPT] = st_r.s2.sens_open;
                st_nxt.prdata[cfs_pkg::ST_DRV] = st_r.drive;
                st_nxt.prdata[cfs_pkg::ST_TRY +: 3] = st_r.tries;
                st_nxt.prdata[cfs_pkg::ST_RS +: 2] = st_r.rs;
                st_nxt.prdata[cfs_pkg::ST_LINE +: 4] = st_r.line;
            end else if (paddr == cfs_pkg::A_CTRL) begin
                st_nxt.prdata[cfs_pkg::CTRL_AUTO] = st_r.auto_en;
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Power-up reset clears every latch and the restart count.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
            st_r.auto_en <= cfs_pkg::CTRL_AUTO_RST;
            // Zero pressure in the empty synchroniser would latch a false loss of
            // charge, so both stages start at the limit, which is not a fault.
            st_r.s1.ret_press <= cfs_pkg::RP_LIMIT;
            st_r.s2.ret_press <= cfs_pkg::RP_LIMIT;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence seq_cf_rise;
        ce_i && !st_r.err[cfs_pkg::P_CF] ##1 st_r.err[cfs_pkg::P_CF];
    endsequence

    sequence seq_hold_window;
        ce_i && st_r.rs == cfs_pkg::RS_WAIT && st_r.s2.cfg_sw
            && st_r.rsec < cfs_pkg::HOLD_SEC && st_r.err[cfs_pkg::P_HE];
    endsequence

    AST_HE_SHUT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && cond[cfs_pkg::P_HE] |=> st_r.err[cfs_pkg::P_HE] && !comp_drive_o)
        else $error("helium over-temperature did not shut down");

    AST_WATER_ALARM: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && st_r.s2.on_req && !(|(cond & cfs_pkg::SHUT_MASK))
            && !(|(st_r.err & cfs_pkg::SHUT_MASK)) |=> comp_drive_o)
        else $error("alarm-class error stopped the drives");

    AST_RP_SHUT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && cond[cfs_pkg::P_RP] |=> diag_err_o[cfs_pkg::P_RP] && !coldhead_drive_o)
        else $error("low return pressure did not shut down");

    AST_TRIES_MAX: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        st_r.tries <= cfs_pkg::MAX_TRIES)
        else $error("restart attempts exceeded the limit");

    AST_NEWEST_TOP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        seq_cf_rise |-> disp_line_o == cfs_pkg::L_CF && disp_state_o != cfs_pkg::DS_OK)
        else $error("newest fault not placed on top");

    AST_MODE2_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        seq_hold_window |=> st_r.err[cfs_pkg::P_HE])
        else $error("helium error cleared inside hold window");

    AST_CH_SKIP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && st_r.drive |=> disp_line_o != cfs_pkg::L_CH)
        else $error("cold-head line shown while running");

    AST_IDLE_HOME: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && st_r.idle_run && tick && st_r.isec == cfs_pkg::IDLE_CNT - 5'h1
            && !up_ev && !dn_ev && st_nxt.err == st_r.err
        |=> disp_line_o == cfs_pkg::L_ET && !st_r.idle_run)
        else $error("display did not return home after idle time");

    AST_LOCAL_MODE2: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && st_r.s2.cfg_sw && !rclr_ev && !soft_clr && (|st_r.err)
            && !(tick && st_r.rs == cfs_pkg::RS_WAIT && st_r.rsec == cfs_pkg::RETRY_SEC - 11'h1)
        |=> (st_r.err & $past(st_r.err)) == $past(st_r.err))
        else $error("local clear accepted in mode 2");

    AST_BTN_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && both_ev && !st_r.s2.cfg_sw && cond == '0 |=> diag_err_o == '0)
        else $error("button clear in mode 1 left an error latched");

    AST_SENS_FAIL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && st_r.s2.sens_open[cfs_pkg::P_HE] && st_nxt.line == cfs_pkg::L_HE
        |=> disp_state_o == cfs_pkg::DS_FAIL)
        else $error("disconnected sensor not shown as failed");

    AST_CFG_SHUT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i && cond[cfs_pkg::P_CF] |=> diag_err_o[cfs_pkg::P_CF] && !comp_drive_o)
        else $error("configuration mismatch did not shut down");

endmodule

// ### src/cfs_pkg.sv
// Constants, types and state layout shared by the compressor fault supervisor.
package cfs_pkg;

    // ==========================================================
    // Clock and time base
    // ==========================================================
    localparam int CLK_HZ      = 200_000_000;   // System clock rate in Hz.
    localparam int SEC_PER_MIN = 60;
    localparam int RETRY_MIN   = 20;            // Spacing of automatic restarts.
    localparam int HOLD_MIN    = 19;            // Clear lockout inside a retry interval.
    localparam int IDLE_SEC    = 30;            // Button idle time before going home.
    localparam logic [10:0] RETRY_SEC = 11'(RETRY_MIN * SEC_PER_MIN);
    localparam logic [10:0] HOLD_SEC  = 11'(HOLD_MIN * SEC_PER_MIN);
    localparam logic [4:0]  IDLE_CNT  = 5'(IDLE_SEC);
    localparam logic [2:0]  MAX_TRIES = 3'h5;   // Automatic restart attempts.

    // ==========================================================
    // Monitor points and limits
    // ==========================================================
    localparam int NPT  = 7;
    localparam int P_HE = 0;                    // Helium discharge temperature.
    localparam int P_WT = 1;                    // Water supply temperature.
    localparam int P_WF = 2;                    // Water flow.
    localparam int P_MT = 3;                    // Motor winding temperature.
    localparam int P_PH = 4;                    // Phase sequence.
    localparam int P_RP = 5;                    // Return pressure.
    localparam int P_CF = 6;                    // Cable versus switch configuration.
    localparam logic [NPT-1:0] SHUT_MASK = 7'h79;   // Shutdown-class points.
    localparam logic [7:0] HE_LIMIT = 8'h5d;    // 93 C.
    localparam logic [7:0] WT_LIMIT = 8'h23;    // 35 C.
    localparam logic [7:0] RP_LIMIT = 8'h0f;    // 15 psig.

    // ==========================================================
    // Display lines and indications
    // ==========================================================
    typedef enum logic [3:0] {
        L_ET = 4'h0, L_HE = 4'h1, L_WT = 4'h2, L_WF = 4'h3,
        L_MT = 4'h4, L_PH = 4'h5, L_RP = 4'h6, L_ADS = 4'h7,
        L_CF = 4'h8, L_RPV = 4'h9, L_SW = 4'ha, L_CH = 4'hb
    } cfs_line_type;
    typedef enum logic [1:0] {
        DS_OK = 2'h0, DS_ERR = 2'h1, DS_FAIL = 2'h2, DS_INFO = 2'h3
    } cfs_disp_type;
    typedef enum logic [1:0] {
        RS_IDLE = 2'h0, RS_WAIT = 2'h1, RS_LOCK = 2'h2
    } cfs_retry_type;

    // Display line that shows each monitor point.
    function automatic cfs_line_type pt_line(input int i);
        case (i)
            P_HE:    pt_line = L_HE;
            P_WT:    pt_line = L_WT;
            P_WF:    pt_line = L_WF;
            P_MT:    pt_line = L_MT;
            P_PH:    pt_line = L_PH;
            P_RP:    pt_line = L_RP;
            default: pt_line = L_CF;
        endcase
    endfunction

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [11:0] A_STATUS = 12'h000;
    localparam logic [11:0] A_CTRL   = 12'h004;
    localparam int CTRL_AUTO = 0;               // Automatic restart enable.
    localparam int CTRL_CLR  = 1;               // Write one: software clear pulse.
    localparam logic CTRL_AUTO_RST = 1'b1;
    localparam int ST_ERR = 0, ST_FAIL = 7, ST_DRV = 14, ST_TRY = 15;
    localparam int ST_RS = 18, ST_LINE = 20;

    // ==========================================================
    // Pin bundle and module state
    // ==========================================================
    typedef struct packed {
        logic [7:0]     he_temp;
        logic [7:0]     water_temp;
        logic [7:0]     ret_press;
        logic           flow_err;
        logic           motor_err;
        logic           phase_err;
        logic           cfg_sw;
        logic           cfg_cable;
        logic           btn_up;
        logic           btn_dn;
        logic           remote_clr;
        logic           on_req;
        logic [NPT-1:0] sens_open;
    } cfs_pin_type;

    typedef struct packed {
        cfs_pin_type    s1;
        cfs_pin_type    s2;
        logic           up_q;
        logic           dn_q;
        logic           rclr_q;
        logic [NPT-1:0] err;
        cfs_line_type   line;
        cfs_disp_type   dstate;
        logic           idle_run;
        logic [4:0]     isec;
        cfs_retry_type  rs;
        logic [2:0]     tries;
        logic [10:0]    rsec;
        logic [27:0]    pre;
        logic           auto_en;
        logic           drive;
        logic [31:0]    prdata;
    } cfs_state_type;

endpackage

// ### bench/cfs_remote.sv
// Remote monitoring partner model on the diagnostic connector.
`timescale 1ns/1ps
module cfs_remote (
    input  wire logic                    sys_clk_i,    // System clock.
    input  wire logic [cfs_pkg::NPT-1:0] diag_err_i,   // Connector error lines.
    output logic                         remote_clr_o  // Momentary clear line.
);
    // Pulse is held four clocks so the two-flop synchroniser sees one clean edge.
    task automatic pulse();
        @(posedge sys_clk_i);
        remote_clr_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        remote_clr_o <= 1'b0;
    endtask
    // The line idles low between pulses.
    initial remote_clr_o = 1'b0;
endmodule

// ### bench/cfs_top_tb.sv
// Self-checking testbench for the compressor fault supervisor.
`timescale 1ns/1ps
module cfs_top_tb;
    logic clk = 1'b0, rst_n = 1'b0, on = 1'b1, cab = 1'b0, rclr, pready, pslverr, e, cd, hd;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sw = 1'b0, bu = 1'b0, bd = 1'b0;
    logic [7:0] he = 8'h30, wt = 8'h14, rp = 8'h40;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [6:0] diag, sens = 7'h00;
    cfs_pkg::cfs_line_type ln;
    cfs_pkg::cfs_disp_type st;
    int seed = 32'h8fd4, n_mismatch = 0, checks_done = 0;
    // 200 MHz clock; TICK_CYCLES shrinks one second to four clocks.
    always #2.5 clk = ~clk;
    cfs_top #(.TICK_CYCLES(4)) cfs_top_i (.sys_clk_i(clk), .reset_n_i(rst_n), .ce_i(1'b1),
        .he_temp_i(he), .water_temp_i(wt), .ret_press_i(rp), .flow_err_i(1'b0),
        .motor_err_i(1'b0), .phase_err_i(1'b0), .cfg_sw_i(sw), .cfg_cable_i(cab),
        .btn_up_i(bu), .btn_dn_i(bd), .remote_clr_i(rclr), .on_req_i(on),
        .sens_open_i(sens), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .comp_drive_o(cd), .coldhead_drive_o(hd), .diag_err_o(diag), .disp_line_o(ln),
        .disp_state_o(st));
    cfs_remote cfs_remote_i (.sys_clk_i(clk), .diag_err_i(diag), .remote_clr_o(rclr));
    // ==========================================================
    // Helpers
    // ==========================================================
    // Expected error lines from the pin values, bit order of the connector.
    function automatic logic [6:0] exp_err(input logic [7:0] h, w, r, input logic c);
        return {c, r < 8'h0f, 3'h0, w > 8'h23, h > 8'h5d};
    endfunction
    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", n, ex, got);
        end
    endtask
    // Request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Pins need three edges to reach the latches; six leaves margin.
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    // Buttons are held one settle time so each edge crosses the synchroniser.
    task automatic press(input logic u, input logic d);
        {bu, bd} <= {u, d};
        settle();
        {bu, bd} <= 2'b00;
        settle();
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl", 32'h1, q);
        apb(1'b0, 12'h008, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        settle();
        chk("diag0", 32'h0, {25'h0, diag});
        // Water limit corners first, then random temperatures around it.
        for (int i = 0; i < 6; i++) begin
            wt <= (i < 2) ? 8'h23 + 8'(i) : 8'h1e + 8'($random(seed) & 15);
            settle();
            chk("diag", {25'h0, exp_err(he, wt, rp, 1'b0)}, {25'h0, diag});
            chk("drive", 32'h1, {31'h0, cd});
            if (wt > 8'h23) chk("line", 32'h2, {28'h0, ln});
            if (wt > 8'h23) chk("state", 32'h1, {30'h0, st});
            wt <= 8'h14;
            settle();
            cfs_remote_i.pulse();
            settle();
            chk("clear", 32'h0, {25'h0, diag});
        end
        // Display: idle return, wrap both ways, cold-head line only while stopped.
        press(1'b0, 1'b1);
        repeat (130) @(posedge clk);
        chk("home", 32'h0, {28'h0, ln});
        press(1'b1, 1'b0);
        chk("wrapup", 32'ha, {28'h0, ln});
        press(1'b0, 1'b1);
        chk("wrapdn", 32'h0, {28'h0, ln});
        press(1'b0, 1'b1);
        chk("okline", 32'h1, {28'h0, ln});
        chk("ok", 32'h0, {30'h0, st});
        sens <= 7'h01;
        settle();
        chk("fail", 32'h2, {30'h0, st});
        sens <= 7'h00;
        on <= 1'b0;
        press(1'b1, 1'b0);
        press(1'b1, 1'b0);
        chk("coldhead", 32'hb, {28'h0, ln});
        press(1'b0, 1'b1);
        chk("wrapch", 32'h0, {28'h0, ln});
        on <= 1'b1;
        // Both buttons clear in mode 1 only; mode 2 takes the connector clear.
        for (int m = 0; m < 2; m++) begin
            {sw, cab} <= {2{m[0]}};
            wt <= 8'h24;
            settle();
            wt <= 8'h14;
            settle();
            press(1'b1, 1'b1);
            chk("btnclr", m ? 32'h2 : 32'h0, {25'h0, diag});
            cfs_remote_i.pulse();
            settle();
            chk("rclr", 32'h0, {25'h0, diag});
        end
        {sw, cab} <= 2'b00;
        // A later shutdown goes on top of an earlier alarm and stops both motors.
        wt <= 8'h24;
        settle();
        rp <= 8'h0e;
        settle();
        chk("top", 32'h6, {28'h0, ln});
        chk("drives", 32'h0, {30'h0, cd, hd});
        {wt, rp} <= {8'h14, 8'h40};
        settle();
        apb(1'b1, 12'h004, 32'h3);
        settle();
        chk("ctrlclr", 32'h0, {25'h0, diag});
        cab <= 1'b1;
        settle();
        chk("cfg", 32'h40, {25'h0, diag});
        cab <= 1'b0;
        cfs_remote_i.pulse();
        // Hot helium in mode 2: drives drop, an early clear is ignored,
        // and one retry follows 1200 ticks later once cooled.
        {sw, cab} <= 2'b11;
        settle();
        he <= 8'h5e;
        settle();
        chk("he", 32'h0, {30'h0, cd, hd});
        he <= 8'h30;
        cfs_remote_i.pulse();
        settle();
        chk("hold", 32'h1, {31'h0, diag[0]});
        repeat (4750) @(posedge clk);
        chk("wait", 32'h1, {31'h0, diag[0]});
        repeat (60) @(posedge clk);
        chk("retry", 32'h1, {31'h0, cd});
        apb(1'b0, 12'h000, 32'h0);
        chk("tries", 32'h1, {29'h0, q[17:15]});
        // A reset in mid-run drops a latched shutdown and the restart count.
        he <= 8'h5e;
        settle();
        chk("he2", 32'h1, {31'h0, diag[0]});
        rst_n <= 1'b0;
        he <= 8'h30;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        apb(1'b0, 12'h000, 32'h0);
        chk("rsterr", 32'h0, {25'h0, q[6:0]});
        chk("rsttry", 32'h0, {29'h0, q[17:15]});
        chk("rstdrv", 32'h1, {31'h0, cd});
        give_verdict();
    end
    // Watchdog sized well beyond the roughly 5300 clocks the scenarios take.
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule
